// [logic/mspc_top.sv]
// spin-up, commutation and speed pulse pin control of the fan driver
`timescale 1ns/100ps
module mspc_top #(
  parameter int HALL_FAST_CYC = mspc_pkg::HALL_FAST_CYC,
  parameter int SS_CYC_PER_US = mspc_pkg::CLK_MHZ
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic hall_input_pos,
  input  wire logic hall_input_neg,
  input  wire logic speed_cmd_in,
  input  wire logic speed_pulse_out_i,
  output logic      speed_pulse_out_o,
  output logic      speed_pulse_out_oe,
  input  wire logic ground_strap_pin,
  output logic      bridge_out_a,
  output logic      bridge_out_b
);
  // ********************************
  // state
  // ********************************
  typedef struct packed {
    mspc_pkg::mspc_state_e st;
    logic                  strap_done;
    logic [1:0]            strap_wait;
    logic                  shared;
    logic                  hall_pol;
    logic [22:0]           hall_cnt;
    logic [4:0]            edge_cnt;
    logic [7:0]            duty;
    logic [23:0]           ramp_cnt;
    logic [11:0]           pw_cnt;
    logic [22:0]           pulse_cnt;
    logic                  half_tog;
    logic [7:0]            sel;
    logic [7:0]            cfg;
    mspc_pkg::mspc_ser_e   sr;
    logic [7:0]            sr_tmr;
    logic [4:0]            sr_bits;
    logic [23:0]           sr_sh;
    logic                  rx_d;
    logic                  out_a;
    logic                  out_b;
    logic                  fg_do;
    logic                  fg_oe;
  } mspc_top_s;

  localparam mspc_top_s RST_S = '{
    st: mspc_pkg::ST_JUDGE,
    sr: mspc_pkg::SR_IDLE,
    sel: mspc_pkg::SPEED_SEL_RST,
    cfg: mspc_pkg::START_CFG_RST,
    default: '0
  };
  localparam logic [22:0] FAST_CYC = 23'(HALL_FAST_CYC);

  mspc_top_s  s_r;
  mspc_top_s  s_nxt;
  logic [4:0] pin_s;
  logic [7:0] cmd_duty;

  mspc_sync #(
    .W (5)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .d       ({ground_strap_pin, speed_pulse_out_i, speed_cmd_in,
                hall_input_neg, hall_input_pos}),
    .q       (pin_s)
  );

  mspc_pwm_meas u_meas (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pwm_s   (pin_s[2]),
    .duty    (cmd_duty)
  );

  // ********************************
  // helpers
  // ********************************
  function automatic logic [1:0] reg_idx(input logic [14:0] a);
    if (a == mspc_pkg::REG_SPEED_SEL) begin
      reg_idx = 2'h1;
    end else if (a == mspc_pkg::REG_START_CFG) begin
      reg_idx = 2'h2;
    end else if (a == mspc_pkg::REG_STATUS) begin
      reg_idx = 2'h3;
    end else begin
      reg_idx = 2'h0;
    end
  endfunction

  function automatic logic [7:0] end_duty(input logic esel);
    end_duty = esel ? mspc_pkg::DUTY_END1 : mspc_pkg::DUTY_END0;
  endfunction

  function automatic logic [23:0] step_cyc(input logic       esel,
                                           input logic [1:0] t);
    int unsigned us;
    int unsigned span;
    case (t)
      2'h0: us = esel ? mspc_pkg::SS_T0B_US : mspc_pkg::SS_T0A_US;
      2'h1: us = mspc_pkg::SS_T1_US;
      2'h2: us = mspc_pkg::SS_T2_US;
      default: us = mspc_pkg::SS_T3_US;
    endcase
    span = 32'(end_duty(esel) - mspc_pkg::DUTY_START);
    step_cyc = 24'(us * SS_CYC_PER_US / span);
  endfunction

  // ********************************
  // next state
  // ********************************
  logic        pol_new;
  logic        hall_edge;
  logic        rot;
  logic        pwm_on;
  logic        esel;
  logic [1:0]  tsel;
  logic [11:0] thr;
  logic        rx;
  logic [23:0] word;
  logic        tach_oe;

  always_comb begin
    s_nxt     = s_r;
    esel      = s_r.cfg[mspc_pkg::SS_END_BIT];
    tsel      = s_r.cfg[mspc_pkg::SS_TIME_LSB +: 2];
    // hold polarity while both inputs agree (no valid differential)
    pol_new   = (pin_s[0] ^ pin_s[1]) ? pin_s[0] : s_r.hall_pol;
    // no edge while the synchroniser still shows its reset value
    hall_edge = s_r.strap_done && pol_new != s_r.hall_pol;
    rot       = s_r.hall_cnt < FAST_CYC;
    thr       = 12'((20'(s_r.duty) * 20'(mspc_pkg::PWM_OUT_CYC)) >> 8);
    pwm_on    = s_r.pw_cnt < thr;
    rx        = s_r.shared ? pin_s[3] : pin_s[2];
    word      = {s_r.sr_sh[22:0], rx};
    tach_oe   = 1'b0;
    if (ce) begin
      // strap caught once, when the synchroniser holds the pin level
      if (!s_r.strap_done) begin
        s_nxt.strap_wait = s_r.strap_wait + 2'h1;
        if (s_r.strap_wait == 2'h2) begin
          s_nxt.strap_done = 1'b1;
          s_nxt.shared     = !pin_s[4];
        end
      end
      // ---- hall tracking ----
      s_nxt.hall_pol = pol_new;
      s_nxt.hall_cnt = (s_r.hall_cnt == '1) ? s_r.hall_cnt
                                            : s_r.hall_cnt + 23'h1;
      if (hall_edge) begin
        s_nxt.hall_cnt = '0;
        s_nxt.edge_cnt = (s_r.edge_cnt >= mspc_pkg::SS_MIN_EDGES)
                         ? s_r.edge_cnt : s_r.edge_cnt + 5'h1;
      end
      // ---- spin-up sequence ----
      case (s_r.st)
        mspc_pkg::ST_JUDGE: begin
          if (hall_edge && s_r.edge_cnt != '0 && rot) begin
            s_nxt.st = mspc_pkg::ST_RUN;
          end else if (!rot) begin
            s_nxt.st = mspc_pkg::ST_WAIT;
          end
        end
        mspc_pkg::ST_WAIT: begin
          if (cmd_duty != '0) begin
            s_nxt.st       = mspc_pkg::ST_SOFT;
            s_nxt.duty     = mspc_pkg::DUTY_START;
            s_nxt.edge_cnt = '0;
            s_nxt.ramp_cnt = '0;
          end
        end
        mspc_pkg::ST_SOFT: begin
          s_nxt.ramp_cnt = s_r.ramp_cnt + 24'h1;
          if (s_r.ramp_cnt >= step_cyc(esel, tsel) - 24'h1) begin
            s_nxt.ramp_cnt = '0;
            if (s_r.duty < end_duty(esel)) begin
              s_nxt.duty = s_r.duty + 8'h01;
            end
          end
          // ramp at end and enough electrical cycles seen
          if (s_r.duty >= end_duty(esel) &&
              s_r.edge_cnt >= mspc_pkg::SS_MIN_EDGES) begin
            s_nxt.st = mspc_pkg::ST_RUN;
          end
        end
        default: begin
          s_nxt.duty = cmd_duty;
        end
      endcase
      // ---- bridge drive, fixed output pwm ----
      s_nxt.pw_cnt = (s_r.pw_cnt == mspc_pkg::PWM_OUT_CYC - 12'h1)
                     ? '0 : s_r.pw_cnt + 12'h1;
      if (s_r.st == mspc_pkg::ST_SOFT || s_r.st == mspc_pkg::ST_RUN) begin
        s_nxt.out_a = s_r.hall_pol && pwm_on;
        s_nxt.out_b = !s_r.hall_pol && pwm_on;
      end else begin
        s_nxt.out_a = 1'b0;
        s_nxt.out_b = 1'b0;
      end
      // ---- speed pulse modes ----
      if (hall_edge) begin
        s_nxt.pulse_cnt = {1'b0, s_r.hall_cnt[22:1]};
        if (pol_new) begin
          s_nxt.half_tog = !s_r.half_tog;
        end
      end else if (s_r.pulse_cnt != '0) begin
        s_nxt.pulse_cnt = s_r.pulse_cnt - 23'h1;
      end
      case (s_r.sel[mspc_pkg::SEL_LSB +: 2])
        mspc_pkg::SEL_X1:   tach_oe = !s_r.hall_pol;
        mspc_pkg::SEL_X2:   tach_oe = s_r.pulse_cnt != '0;
        mspc_pkg::SEL_HALF: tach_oe = s_r.half_tog;
        default:            tach_oe = rot;
      endcase
      // ---- serial register port ----
      s_nxt.rx_d   = rx;
      s_nxt.sr_tmr = (s_r.sr_tmr == '0) ? '0 : s_r.sr_tmr - 8'h01;
      case (s_r.sr)
        mspc_pkg::SR_IDLE: begin
          if (s_r.strap_done && s_r.rx_d && !rx) begin
            s_nxt.sr      = mspc_pkg::SR_RX;
            s_nxt.sr_tmr  = mspc_pkg::SER_BIT_CYC + mspc_pkg::SER_HALF_CYC;
            s_nxt.sr_bits = '0;
          end
        end
        mspc_pkg::SR_RX: begin
          if (s_r.sr_tmr == '0) begin
            s_nxt.sr_sh   = word;
            s_nxt.sr_bits = s_r.sr_bits + 5'h1;
            s_nxt.sr_tmr  = mspc_pkg::SER_BIT_CYC;
            if (s_r.sr_bits == mspc_pkg::SER_REQ_BITS - 5'h1) begin
              s_nxt.sr = mspc_pkg::SR_IDLE;
              if (word[23]) begin
                if (reg_idx(word[22:8]) == 2'h1) begin
                  s_nxt.sel = word[7:0];
                end else if (reg_idx(word[22:8]) == 2'h2) begin
                  s_nxt.cfg = word[7:0];
                end
              end else begin
                // answer: start bit, data lsb first, stop bit
                s_nxt.sr      = mspc_pkg::SR_TX;
                s_nxt.sr_bits = '0;
                if (reg_idx(word[22:8]) == 2'h1) begin
                  s_nxt.sr_sh = {14'h0, 1'b1, s_r.sel, 1'b0};
                end else if (reg_idx(word[22:8]) == 2'h2) begin
                  s_nxt.sr_sh = {14'h0, 1'b1, s_r.cfg, 1'b0};
                end else if (reg_idx(word[22:8]) == 2'h3) begin
                  s_nxt.sr_sh = {14'h0, 1'b1, 2'h0, s_r.hall_pol,
                                 s_r.shared, 4'(s_r.st), 1'b0};
                end else begin
                  s_nxt.sr_sh = {14'h0, 1'b1, 8'h00, 1'b0};
                end
              end
            end
          end
        end
        default: begin
          if (s_r.sr_tmr == '0) begin
            s_nxt.sr_tmr  = mspc_pkg::SER_BIT_CYC;
            s_nxt.sr_sh   = {1'b1, s_r.sr_sh[23:1]};
            s_nxt.sr_bits = s_r.sr_bits + 5'h1;
            if (s_r.sr_bits == mspc_pkg::SER_ANS_BITS - 5'h1) begin
              s_nxt.sr = mspc_pkg::SR_IDLE;
            end
          end
        end
      endcase
      // ---- pin: pull low or release only ----
      s_nxt.fg_do = 1'b0;
      if (s_r.sr == mspc_pkg::SR_TX) begin
        s_nxt.fg_oe = !s_r.sr_sh[0];
      end else if (s_r.shared || s_r.sr == mspc_pkg::SR_RX) begin
        s_nxt.fg_oe = 1'b0;
      end else begin
        s_nxt.fg_oe = tach_oe;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= RST_S;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign speed_pulse_out_o  = s_r.fg_do;
  assign speed_pulse_out_oe = s_r.fg_oe;
  assign bridge_out_a       = s_r.out_a;
  assign bridge_out_b       = s_r.out_b;

  // ********************************
  // checks
  // ********************************
  a_fg_open_drain: assert property (@(posedge clk) disable iff (sys_rst)
    !speed_pulse_out_o)
    else $error("speed pulse pin driven high");
  a_fg_tracks_hall: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && s_r.sr == mspc_pkg::SR_IDLE && !s_r.shared && s_r.strap_done
     && s_r.sel[1:0] == mspc_pkg::SEL_X1) |=>
    speed_pulse_out_oe == !$past(s_r.hall_pol))
    else $error("speed pulse not following hall");
  a_half_rate_tog: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && hall_edge && pol_new) |=> $changed(s_r.half_tog))
    else $error("half rate toggle missed");
  a_run_follows_cmd: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && s_r.st == mspc_pkg::ST_RUN) |=> s_r.duty == $past(cmd_duty))
    else $error("run duty not following command");
  a_bridge_dir: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && s_r.hall_pol) |=> !bridge_out_b)
    else $error("bridge direction against hall polarity");
  a_soft_entry_duty: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && s_r.st == mspc_pkg::ST_WAIT && cmd_duty != '0) |=>
    s_r.st == mspc_pkg::ST_SOFT && s_r.duty == mspc_pkg::DUTY_START)
    else $error("soft start did not begin at start duty");
  a_ramp_bounded: assert property (@(posedge clk) disable iff (sys_rst)
    s_r.st == mspc_pkg::ST_SOFT |-> s_r.duty >= mspc_pkg::DUTY_START &&
    s_r.duty <= end_duty(esel))
    else $error("soft start duty out of range");
  a_soft_min_cycles: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(s_r.st) == mspc_pkg::ST_SOFT && s_r.st == mspc_pkg::ST_RUN) |->
    $past(s_r.edge_cnt) >= mspc_pkg::SS_MIN_EDGES)
    else $error("soft start left too early");
  a_fast_skip: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && s_r.st == mspc_pkg::ST_JUDGE && hall_edge && rot &&
     s_r.edge_cnt != '0) |=> s_r.st == mspc_pkg::ST_RUN)
    else $error("fast rotor did not skip soft start");
  a_shared_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && s_r.shared && s_r.sr != mspc_pkg::SR_TX) |=>
    !speed_pulse_out_oe)
    else $error("shared line driven outside answer");
  c_soft_to_run: cover property (@(posedge clk) disable iff (sys_rst)
    $past(s_r.st) == mspc_pkg::ST_SOFT && s_r.st == mspc_pkg::ST_RUN);
  c_judge_to_run: cover property (@(posedge clk) disable iff (sys_rst)
    $past(s_r.st) == mspc_pkg::ST_JUDGE && s_r.st == mspc_pkg::ST_RUN);
  c_ser_answer: cover property (@(posedge clk) disable iff (sys_rst)
    s_r.sr == mspc_pkg::SR_TX);
  c_double_rate: cover property (@(posedge clk) disable iff (sys_rst)
    s_r.sel[1:0] == mspc_pkg::SEL_X2 && speed_pulse_out_oe);
endmodule // mspc_top

// [logic/mspc_pkg.sv]
// constants and types shared by the spin-up and pin control block
package mspc_pkg;
  // ********************************
  // clock and register map
  // ********************************
  localparam int          CLK_MHZ       = 100;
  localparam logic [14:0] REG_SPEED_SEL = 15'h0027;
  localparam logic [14:0] REG_START_CFG = 15'h0028;
  localparam logic [14:0] REG_STATUS    = 15'h0029;
  localparam logic [7:0]  SPEED_SEL_RST = 8'h00;
  localparam logic [7:0]  START_CFG_RST = 8'h00;
  localparam int          SEL_LSB       = 0;
  localparam int          SS_END_BIT    = 0;
  localparam int          SS_TIME_LSB   = 1;
  localparam logic [1:0]  SEL_X1        = 2'h0;
  localparam logic [1:0]  SEL_X2        = 2'h1;
  localparam logic [1:0]  SEL_HALF      = 2'h2;
  localparam logic [1:0]  SEL_RD        = 2'h3;

  // ********************************
  // soft start
  // ********************************
  localparam int         DUTY_START_PCT = 4;
  localparam int         DUTY_END0_PCT  = 24;
  localparam int         DUTY_END1_PCT  = 54;
  localparam logic [7:0] DUTY_START     = 8'(DUTY_START_PCT * 256 / 100);
  localparam logic [7:0] DUTY_END0      = 8'(DUTY_END0_PCT * 256 / 100);
  localparam logic [7:0] DUTY_END1      = 8'(DUTY_END1_PCT * 256 / 100);
  localparam int         SS_MIN_ECYC    = 8;
  localparam logic [4:0] SS_MIN_EDGES   = 5'(SS_MIN_ECYC * 2);
  localparam int         SS_T0A_US      = 2000;
  localparam int         SS_T0B_US      = 100000;
  localparam int         SS_T1_US       = 500000;
  localparam int         SS_T2_US       = 1000000;
  localparam int         SS_T3_US       = 2000000;

  // ********************************
  // speed judgement, output pwm, serial
  // ********************************
  localparam int     FAST_RPM      = 304;
  localparam int     EDGES_PER_REV = 4;
  localparam longint HALL_FAST_L   =
    longint'(CLK_MHZ) * 60000000 / (FAST_RPM * EDGES_PER_REV);
  localparam int     HALL_FAST_CYC = int'(HALL_FAST_L);
  localparam int     PWM_OUT_KHZ   = 48;
  localparam logic [11:0] PWM_OUT_CYC = 12'(CLK_MHZ * 1000 / PWM_OUT_KHZ);
  localparam int     SER_BIT_NS    = 1000;
  localparam logic [7:0] SER_BIT_CYC = 8'(CLK_MHZ * SER_BIT_NS / 1000);
  localparam logic [7:0] SER_HALF_CYC = 8'(CLK_MHZ * SER_BIT_NS / 2000);
  localparam logic [4:0] SER_REQ_BITS = 5'd24;
  localparam logic [4:0] SER_ANS_BITS = 5'd10;
  localparam logic [6:0] MEAS_DIV_CYC = 7'd127;

  typedef enum logic [3:0] {
    ST_JUDGE = 4'h1,
    ST_WAIT  = 4'h2,
    ST_SOFT  = 4'h4,
    ST_RUN   = 4'h8
  } mspc_state_e;

  typedef enum logic [2:0] {
    SR_IDLE = 3'h1,
    SR_RX   = 3'h2,
    SR_TX   = 3'h4
  } mspc_ser_e;
endpackage

// [logic/mspc_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module mspc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mspc_sync_s;

  mspc_sync_s s_r;
  mspc_sync_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (ce) begin
      s_nxt.s1 = d;
      s_nxt.s2 = s_r.s1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.s2;
endmodule // mspc_sync

// [logic/mspc_pwm_meas.sv]
// duty measurement of the speed command input, 8-bit result
`timescale 1ns/100ps
module mspc_pwm_meas (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       pwm_s,
  output logic      [7:0] duty
);
  typedef struct packed {
    logic [6:0] div;
    logic [7:0] smp;
    logic [8:0] hi;
    logic [7:0] duty;
  } mspc_meas_s;

  mspc_meas_s s_r;
  mspc_meas_s s_nxt;
  logic [8:0] hi_sum;

  // 256 samples span several input periods, so the window averages
  always_comb begin
    s_nxt  = s_r;
    hi_sum = s_r.hi + {8'h00, pwm_s};
    if (ce) begin
      s_nxt.div = s_r.div + 7'h01;
      if (s_r.div == mspc_pkg::MEAS_DIV_CYC) begin
        s_nxt.div = '0;
        s_nxt.smp = s_r.smp + 8'h01;
        s_nxt.hi  = hi_sum;
        if (s_r.smp == 8'hff) begin
          s_nxt.hi   = '0;
          s_nxt.duty = hi_sum[8] ? 8'hff : hi_sum[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign duty = s_r.duty;
endmodule // mspc_pwm_meas

// [sim/mspc_hall_model.sv]
// hall sensor model: complementary outputs toggling at a fixed rate
`timescale 1ns/100ps
module mspc_hall_model #(
  parameter int HALF_CYC = 1500
) (
  clk,
  run,
  hall_input_pos,
  hall_input_neg
);
  input  wire logic clk;
  input  wire logic run;
  output logic      hall_input_pos;
  output logic      hall_input_neg;

  int cnt;

  // ********************************
  // rotor
  // ********************************
  // free of the device reset: the rotor keeps turning through it
  initial begin
    hall_input_pos = 1'b0;
    cnt = 0;
  end
  always @(posedge clk) begin
    if (run) begin
      if (cnt >= HALF_CYC - 1) begin
        cnt <= 0;
        hall_input_pos <= ~hall_input_pos;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
  assign hall_input_neg = ~hall_input_pos;
endmodule // mspc_hall_model

// [sim/tb_motor_spinup_and_pin_control.sv]
// testbench for the spin-up and speed pulse pin control block
`timescale 1ns/100ps
module tb_motor_spinup_and_pin_control;
  logic       clk;
  logic       sys_rst;
  logic       strap;
  logic       ser_line;
  logic       pwm_line;
  logic       pwm_en;
  logic       hall_run;
  logic       hall_input_pos;
  logic       hall_input_neg;
  logic       pin_o;
  logic       pin_oe;
  logic       pin_w;
  logic       pin_d;
  logic       cmd_w;
  logic       bridge_out_a;
  logic       bridge_out_b;
  logic [7:0] h_hist;
  logic [7:0] rd;
  int         num_errors;
  int         checked;
  int         n;
  int         e;
  int         f0;
  int         falls;
  int         pcnt;
  localparam int FALLS [4] = '{2, 4, 1, 0};

  // pull-up on the speed pulse wire; bench pulls low as serial master while strap is low
  assign pin_w = ~pin_oe & (strap | ser_line);
  assign cmd_w = strap ? ser_line : pwm_line;

  mspc_top #(
    .HALL_FAST_CYC(2000),
    .SS_CYC_PER_US(1)
  ) u_mspc_top (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .ce                (1'b1),
    .hall_input_pos    (hall_input_pos),
    .hall_input_neg    (hall_input_neg),
    .speed_cmd_in      (cmd_w),
    .speed_pulse_out_i (pin_w),
    .speed_pulse_out_o (pin_o),
    .speed_pulse_out_oe(pin_oe),
    .ground_strap_pin  (strap),
    .bridge_out_a      (bridge_out_a),
    .bridge_out_b      (bridge_out_b)
  );

  mspc_hall_model #(
    .HALF_CYC(1500)
  ) u_mspc_hall_model (
    .clk           (clk),
    .run           (hall_run),
    .hall_input_pos(hall_input_pos),
    .hall_input_neg(hall_input_neg)
  );

  // ********************************
  // clock, command pwm, monitors
  // ********************************
  initial begin
    clk = 1'b0;
  end
  always #5 clk = ~clk;

  always @(posedge clk) begin
    pcnt <= (pcnt == 1999) ? 0 : pcnt + 1;
    pwm_line <= pwm_en & (pcnt < 1000);
    h_hist <= {h_hist[6:0], hall_input_pos};
    pin_d <= pin_w;
    if (pin_d & ~pin_w)
      falls++;
    if (!sys_rst) begin
      if (pin_o !== 1'b0) fail("pulse pin driven high");
      if (bridge_out_a & bridge_out_b) fail("both bridges on");
      if (h_hist == 8'h00 && bridge_out_a) fail("bridge a, hall low");
      if (h_hist == 8'hff && bridge_out_b) fail("bridge b, hall high");
    end
  end

  // ********************************
  // tasks
  // ********************************
  task automatic fail(input string m);
    num_errors++;
    $display("CHECK FAILED t=%0t %s", $time, m);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    checked++;
    if (got !== exp) fail(m);
  endtask

  task automatic range(input int v, input int lo, input int hi,
                       input string m);
    checked++;
    if (v < lo || v > hi) fail(m);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // one serial frame, msb first; a read returns the answer byte
  task automatic frame(input logic wr, input logic [14:0] a,
                       input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    int          t;
    f = {wr, a, wr ? d : 8'hff};
    q = 8'h00;
    ser_line <= 1'b0;
    cyc(100);
    for (int i = 23; i >= 1; i--) begin
      ser_line <= f[i];
      cyc(100);
    end
    ser_line <= f[0];
    if (wr) begin
      cyc(100);
    end else begin
      // answer start bit begins before our last bit time is over
      t = 0;
      while (pin_w !== 1'b0 && t < 300) begin
        cyc(1);
        t++;
      end
      range(t, 0, 299, "no answer");
      cyc(150);
      for (int i = 0; i < 8; i++) begin
        q[i] = pin_w;
        cyc(100);
      end
      cyc(100);
    end
    ser_line <= 1'b1;
    cyc(150);
  endtask

  task automatic on_count(input int k, output int c);
    c = 0;
    repeat (k) begin
      @(posedge clk);
      if (bridge_out_a | bridge_out_b)
        c++;
    end
  endtask

  task automatic end_of_test;
    $display("num_errors %0d checked %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (150000) @(posedge clk);
    fail("watchdog");
    end_of_test();
  end

  // ********************************
  // tests
  // ********************************
  initial begin
    sys_rst = 1'b1;
    strap = 1'b0;
    ser_line = 1'b1;
    pwm_en = 1'b0;
    pwm_line = 1'b0;
    hall_run = 1'b0;
    h_hist = 8'h00;
    pin_d = 1'b1;
    pcnt = 0;
    falls = 0;
    num_errors = 0;
    checked = 0;
    cyc(8);
    sys_rst <= 1'b0;
    cyc(10);
    pwm_en <= 1'b1;
    frame(1'b0, mspc_pkg::REG_SPEED_SEL, 8'h00, rd);
    chk(rd, mspc_pkg::SPEED_SEL_RST, "select reset");
    frame(1'b0, mspc_pkg::REG_START_CFG, 8'h00, rd);
    chk(rd, mspc_pkg::START_CFG_RST, "start cfg reset");
    frame(1'b1, mspc_pkg::REG_SPEED_SEL, {6'h00, mspc_pkg::SEL_HALF}, rd);
    frame(1'b0, mspc_pkg::REG_SPEED_SEL, 8'h00, rd);
    chk(rd, {6'h00, mspc_pkg::SEL_HALF}, "select readback");
    frame(1'b0, 15'h0100, 8'h00, rd);
    chk(rd, 8'h00, "unmapped read");
    frame(1'b1, mspc_pkg::REG_STATUS, 8'hff, rd);
    frame(1'b0, mspc_pkg::REG_STATUS, 8'h00, rd);
    chk(rd & 8'h10, 8'h10, "strap ground flag");
    // hall held still so soft start cannot end before we look
    n = 0;
    while (!(bridge_out_a | bridge_out_b) && n < 40000) begin
      cyc(1);
      n++;
    end
    range(n, 0, 39999, "no spin-up");
    hall_run <= 1'b1;
    on_count(2083, n);
    range(n, 240, 360, "ramp duty");
    frame(1'b0, mspc_pkg::REG_STATUS, 8'h00, rd);
    chk(rd & 8'h1f, 8'h14, "not in soft start");
    e = int'(mspc_pkg::DUTY_END0) * 4166 / 256;
    on_count(4166, n);
    range(n, e * 9 / 10, e * 11 / 10, "end duty");
    cyc(14000);
    frame(1'b0, mspc_pkg::REG_STATUS, 8'h00, rd);
    chk(rd & 8'h1f, 8'h18, "no steady run");
    e = 128 * 4166 / 256;
    on_count(4166, n);
    range(n, e * 9 / 10, e * 11 / 10, "run duty");
    // strap to regulator with the rotor already turning fast
    strap <= 1'b1;
    sys_rst <= 1'b1;
    cyc(8);
    sys_rst <= 1'b0;
    cyc(3000);
    frame(1'b0, mspc_pkg::REG_STATUS, 8'h00, rd);
    chk(rd & 8'h1f, 8'h08, "soft start not skipped");
    for (int m = 0; m < 4; m++) begin
      frame(1'b1, mspc_pkg::REG_SPEED_SEL, 8'(m), rd);
      @(posedge hall_input_pos);
      cyc(200);
      f0 = falls;
      cyc(6000);
      chk(8'(falls - f0), 8'(FALLS[m]), "pulse count");
    end
    chk({7'h00, pin_w}, 8'h00, "rotation detect level");
    end_of_test();
  end
endmodule // tb_motor_spinup_and_pin_control
